// ===== logic/bsljx_defines.vh
// Constants for the bit search, range clamp and long jump execution unit
`ifndef BSLJX_DEFINES_VH
`define BSLJX_DEFINES_VH

// ****************************************************************
// Register map, byte addresses on the APB side
// ****************************************************************
`define BSLJX_ADDR_IR        8'h00
`define BSLJX_ADDR_SR        8'h04
`define BSLJX_ADDR_PC        8'h08
`define BSLJX_ADDR_STAT      8'h0C
`define BSLJX_WREG_PAGE      2'h1
`define BSLJX_DMEM_PAGE      2'h2

// ****************************************************************
// Status flag positions and reset values
// ****************************************************************
`define BSLJX_SR_C           0
`define BSLJX_SR_Z           1
`define BSLJX_SR_OV          2
`define BSLJX_SR_N           3
`define BSLJX_SR_RST         4'h0
`define BSLJX_PC_RST         23'h000000
`define BSLJX_IR_RST         24'h000000
`define BSLJX_NOP_WORD       24'h000000
`define BSLJX_STAT_WAIT2     0
`define BSLJX_STAT_UNKNOWN   1

// ****************************************************************
// Instruction word fields
// ****************************************************************
`define BSLJX_FF1_PFX        12'hCF0
`define BSLJX_CLAMP_PFX      8'hE4
`define BSLJX_CLAMPX_PFX     8'hE5
`define BSLJX_JUMP_PFX       8'h04
`define BSLJX_JUMP2_PFX      17'h00000
`define BSLJX_F_X            15
`define BSLJX_F_W_HI         14
`define BSLJX_F_W_LO         11
`define BSLJX_F_D_HI         10
`define BSLJX_F_D_LO         7
`define BSLJX_F_P_HI         6
`define BSLJX_F_P_LO         4
`define BSLJX_F_S_HI         3
`define BSLJX_F_S_LO         0

// ****************************************************************
// Source addressing modes and step sizes
// ****************************************************************
`define BSLJX_AM_DIRECT      3'h0
`define BSLJX_AM_IND         3'h1
`define BSLJX_AM_POSTINC     3'h2
`define BSLJX_AM_POSTDEC     3'h3
`define BSLJX_AM_PREINC      3'h4
`define BSLJX_AM_PREDEC      3'h5
`define BSLJX_WORD_STEP      16'h0002
`define BSLJX_PC_STEP        23'h000002

`endif

// ===== logic/bsljx_exec_core.v
// Execution unit for bit search, signed range clamp and direct long jump
//
// Summary of operation
// - Scan source from bit 0 upward, report index plus one
// - No set bit gives zero, carry set
// - Word only, one word, one cycle
// - Decode prefix CF0 with d, p, s fields
// - Compare signed source with even/odd limit pair
// - Above upper: load upper, clear Z N OV
// - Below lower: load lower, N set, Z OV clear
// - Within limits: source kept, Z set
// - Overflow flag always cleared by clamp ops
// - Upper limit test has priority
// - Decode clamp prefix E4 with w, p, s
// - Excess above: difference or plus one to dest
// - Excess below: difference or minus one to dest
// - Excess within: destination cleared
// - Decode excess prefix E5 with x, d fields
// - Jump loads 23-bit target, bit 0 forced low
// - Jump replaces fetched instruction with no-op
// - Jump target assembled from two words
`timescale 1ns/1ps
`default_nettype none
`include "bsljx_defines.vh"

module bsljx_exec_core (
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_EXEC  = 2'h1;
  localparam [1:0] ST_JUMP2 = 2'h2;
  localparam [1:0] ST_JLOAD = 2'h3;

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [15:0] wreg_ff [0:15];
  reg  [15:0] dmem_ff [0:15];
  reg  [23:0] ir_ff;
  reg  [22:0] pc_ff;
  reg  [3:0]  sr_ff;
  reg  [1:0]  state_ff;
  reg  [15:0] jump_lo_ff;
  reg         unknown_ff;
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  integer     idx;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Index of lowest set bit, 1 for bit 0 up to 16 for bit 15, 0 if none
  function [4:0] ff1_lsb;
    input [15:0] word;
    integer i;
    begin
      ff1_lsb = 5'h00;
      for (i = 15; i >= 0; i = i - 1)
      begin
        if (word[i])
          ff1_lsb = i[4:0] + 5'h01;
      end
    end
  endfunction

  // Aligned word inside one 64-byte page of the map
  function page_hit;
    input [7:0] addr;
    input [1:0] page;
    begin
      page_hit = (addr[7:6] == page) && (addr[1:0] == 2'h0);
    end
  endfunction

  // Address map check, shared by read and write paths
  function addr_ok;
    input [7:0] addr;
    begin
      addr_ok = (addr == `BSLJX_ADDR_IR) || (addr == `BSLJX_ADDR_SR) ||
                (addr == `BSLJX_ADDR_PC) || (addr == `BSLJX_ADDR_STAT) ||
                page_hit(addr, `BSLJX_WREG_PAGE) ||
                page_hit(addr, `BSLJX_DMEM_PAGE);
    end
  endfunction

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  wire        apb_acc  = i_psel & i_penable;
  wire        map_hit  = addr_ok(i_paddr);
  wire        apb_wr   = apb_acc & pready_ff & i_pwrite & map_hit;
  // Instruction launch, taken in idle and while awaiting a jump's second word
  wire        ir_wr    = apb_wr & (i_paddr == `BSLJX_ADDR_IR);
  wire        nxt_pready = apb_acc & ~pready_ff;
  reg  [31:0] nxt_prdata;

  // Read mux, unmapped words read as zero
  always @*
  begin
    nxt_prdata = 32'h00000000;
    if (i_paddr == `BSLJX_ADDR_IR)
      nxt_prdata = {8'h00, ir_ff};
    else if (i_paddr == `BSLJX_ADDR_SR)
      nxt_prdata = {28'h0000000, sr_ff};
    else if (i_paddr == `BSLJX_ADDR_PC)
      nxt_prdata = {9'h000, pc_ff};
    else if (i_paddr == `BSLJX_ADDR_STAT)
      nxt_prdata = {30'h00000000, unknown_ff, state_ff == ST_JUMP2};
    else if (page_hit(i_paddr, `BSLJX_WREG_PAGE))
      nxt_prdata = {16'h0000, wreg_ff[i_paddr[5:2]]};
    else if (page_hit(i_paddr, `BSLJX_DMEM_PAGE))
      nxt_prdata = {16'h0000, dmem_ff[i_paddr[5:2]]};
  end

  // One wait state so that data and ready both leave flip-flops
  // Ready is a one-cycle pulse; a held access is answered again every second cycle
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_pready ? nxt_prdata : 32'h00000000;
      pslverr_ff <= nxt_pready & ~map_hit;
    end
  end

  assign o_prdata  = prdata_ff;
  assign o_pready  = pready_ff;
  assign o_pslverr = pslverr_ff;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  wire [3:0] f_s = ir_ff[`BSLJX_F_S_HI:`BSLJX_F_S_LO];
  wire [2:0] f_p = ir_ff[`BSLJX_F_P_HI:`BSLJX_F_P_LO];
  wire [3:0] f_d = ir_ff[`BSLJX_F_D_HI:`BSLJX_F_D_LO];
  wire [3:0] f_w = ir_ff[`BSLJX_F_W_HI:`BSLJX_F_W_LO];
  wire       f_x = ir_ff[`BSLJX_F_X];

  // Prefixes compare the whole opcode field; no partial matches
  wire is_ff1    = (ir_ff[23:12] == `BSLJX_FF1_PFX);
  wire is_clamp  = (ir_ff[23:16] == `BSLJX_CLAMP_PFX);
  wire is_clampx = (ir_ff[23:16] == `BSLJX_CLAMPX_PFX);
  wire is_jump   = (ir_ff[23:16] == `BSLJX_JUMP_PFX);

  // ****************************************************************
  // Source operand fetch and pointer update
  // ****************************************************************
  reg  [15:0] src_ptr;
  reg  [15:0] ea;
  reg  [15:0] ptr_new;
  reg         ptr_upd;
  reg  [15:0] operand;

  // Pre modes address the stepped pointer, post modes the old one
  always @*
  begin
    src_ptr = wreg_ff[f_s];
    ea      = src_ptr;
    ptr_new = src_ptr;
    ptr_upd = 1'b0;
    case (f_p)
      `BSLJX_AM_POSTINC:
      begin
        ptr_new = src_ptr + `BSLJX_WORD_STEP;
        ptr_upd = 1'b1;
      end
      `BSLJX_AM_POSTDEC:
      begin
        ptr_new = src_ptr - `BSLJX_WORD_STEP;
        ptr_upd = 1'b1;
      end
      `BSLJX_AM_PREINC:
      begin
        ptr_new = src_ptr + `BSLJX_WORD_STEP;
        ea      = ptr_new;
        ptr_upd = 1'b1;
      end
      `BSLJX_AM_PREDEC:
      begin
        ptr_new = src_ptr - `BSLJX_WORD_STEP;
        ea      = ptr_new;
        ptr_upd = 1'b1;
      end
      default:
      begin
        ptr_upd = 1'b0;
      end
    endcase
    // Data words alias every 32 bytes; only address bits 4:1 are decoded
    operand = (f_p == `BSLJX_AM_DIRECT) ? src_ptr : dmem_ff[ea[4:1]];
  end

  // ****************************************************************
  // Clamp comparison, both limits tested in the same cycle
  // ****************************************************************
  wire [15:0] upper_limit_reg = wreg_ff[{f_w[3:1], 1'b0}];
  wire [15:0] lower_limit     = wreg_ff[{f_w[3:1], 1'b1}];
  wire        above = $signed(operand) > $signed(upper_limit_reg);
  wire        below = $signed(operand) < $signed(lower_limit);
  // Differences wrap in 16 bits; the excess is not saturated
  wire [15:0] diff_up = operand - upper_limit_reg;
  wire [15:0] diff_lo = operand - lower_limit;
  reg  [15:0] clamp_val;
  reg  [15:0] excess;
  reg  [3:0]  clamp_sr;

  // Upper test first, so a source between inverted limits writes the upper value
  always @*
  begin
    clamp_sr = sr_ff;
    clamp_sr[`BSLJX_SR_OV] = 1'b0;
    if (above)
    begin
      clamp_val = upper_limit_reg;
      excess    = f_x ? diff_up : 16'h0001;
      clamp_sr[`BSLJX_SR_Z] = 1'b0;
      clamp_sr[`BSLJX_SR_N] = 1'b0;
    end
    else if (below)
    begin
      clamp_val = lower_limit;
      excess    = f_x ? diff_lo : 16'hFFFF;
      clamp_sr[`BSLJX_SR_Z] = 1'b0;
      clamp_sr[`BSLJX_SR_N] = 1'b1;
    end
    else
    begin
      clamp_val = operand;
      excess    = 16'h0000;
      clamp_sr[`BSLJX_SR_Z] = 1'b1;
      clamp_sr[`BSLJX_SR_N] = 1'b0;
    end
  end

  // ****************************************************************
  // Bit search result
  // ****************************************************************
  wire [4:0]  ff1_idx = ff1_lsb(operand);
  wire [15:0] ff1_res = {11'h000, ff1_idx};

  // ****************************************************************
  // Sequencer, register file, memory, flags and program counter
  // ****************************************************************
  // Exec is one cycle after the IR write; the APB wait state keeps the
  // next bus write at least two edges away, so the paths never collide.
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      // Storage clears too, so reads after reset are defined
      for (idx = 0; idx < 16; idx = idx + 1)
      begin
        wreg_ff[idx] <= 16'h0000;
        dmem_ff[idx] <= 16'h0000;
      end
      ir_ff      <= `BSLJX_IR_RST;
      pc_ff      <= `BSLJX_PC_RST;
      sr_ff      <= `BSLJX_SR_RST;
      state_ff   <= ST_IDLE;
      jump_lo_ff <= 16'h0000;
      unknown_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (ir_wr)
          begin
            ir_ff    <= i_pwdata[23:0];
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          state_ff   <= ST_IDLE;
          unknown_ff <= 1'b0;
          pc_ff      <= pc_ff + `BSLJX_PC_STEP;
          if (is_jump)
          begin
            jump_lo_ff <= ir_ff[15:0];
            pc_ff      <= pc_ff;
            state_ff   <= ST_JUMP2;
          end
          else if (is_ff1 || is_clamp || is_clampx)
          begin
            // Pointer first, so a write to the same register wins below
            if (ptr_upd)
              wreg_ff[f_s] <= ptr_new;
            if (is_ff1)
            begin
              wreg_ff[f_d] <= ff1_res;
              sr_ff[`BSLJX_SR_C] <= (ff1_idx == 5'h00);
            end
            else
            begin
              if (f_p == `BSLJX_AM_DIRECT)
                wreg_ff[f_s] <= clamp_val;
              else
                dmem_ff[ea[4:1]] <= clamp_val;
              if (is_clampx)
                wreg_ff[f_d] <= excess;
              sr_ff <= clamp_sr;
            end
          end
          // Unrecognised words still step the counter and are flagged
          else
            unknown_ff <= 1'b1;
        end
        ST_JUMP2:
        begin
          // Second word taken as is; its upper bits are not checked
          if (ir_wr)
          begin
            ir_ff    <= i_pwdata[23:0];
            state_ff <= ST_JLOAD;
          end
        end
        ST_JLOAD:
        begin
          // Target bits 22:16 come from the second word, bit 0 dropped
          // No word step here: the jump sets the counter outright
          pc_ff    <= {ir_ff[6:0], jump_lo_ff[15:1], 1'b0};
          ir_ff    <= `BSLJX_NOP_WORD;
          state_ff <= ST_IDLE;
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
      // Software access to the architectural state in idle and while awaiting a jump's second word
      // A write landing in EXEC or JLOAD would be lost; bus timing keeps it out
      if (apb_wr && state_ff != ST_EXEC && state_ff != ST_JLOAD)
      begin
        if (i_paddr == `BSLJX_ADDR_SR)
          sr_ff <= i_pwdata[3:0];
        if (i_paddr == `BSLJX_ADDR_PC)
          pc_ff <= {i_pwdata[22:1], 1'b0};
        if (page_hit(i_paddr, `BSLJX_WREG_PAGE))
          wreg_ff[i_paddr[5:2]] <= i_pwdata[15:0];
        if (page_hit(i_paddr, `BSLJX_DMEM_PAGE))
          dmem_ff[i_paddr[5:2]] <= i_pwdata[15:0];
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/bsljx_exec_asserts.sv
// Bus timing and result checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
`include "bsljx_defines.vh"
module bsljx_exec_asserts (
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr
);
  // ****************************************
  // Properties, all on the one clock
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // Holes in the map and misaligned words
  wire hole = (i_paddr > 8'h0C && i_paddr < 8'h40) || i_paddr >= 8'hC0 || |i_paddr[1:0];

  AST_READY_LAT: assert property (i_psel && !i_penable |-> ##2 o_pready)
    else $error("answer not two cycles after setup");
  AST_READY_ONE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_READY_ACC: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access phase");
  AST_NO_SEL: assert property (!i_psel |=> !o_pready)
    else $error("ready without select");
  AST_DATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  AST_ERR_QUAL: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_ERR_HOLE: assert property (o_pready && hole |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_PC_EVEN: assert property (o_pready && !i_pwrite && i_paddr == `BSLJX_ADDR_PC
    |-> !o_pslverr && o_prdata[0] == 1'b0 && o_prdata[31:23] == 9'h0)
    else $error("counter odd or wide");
  // Within the working page only aligned words are mapped; others are refused
  AST_W_ZEXT: assert property (o_pready && !i_pwrite && i_paddr[7:6] == 2'b01
    && i_paddr[1:0] == 2'b00 |-> !o_pslverr && o_prdata[31:16] == 16'h0)
    else $error("working word not zero extended");
endmodule

bind bsljx_exec_core bsljx_exec_asserts u_chk (
  .i_sys_clk (i_sys_clk),
  .i_rstn    (i_rstn),
  .i_psel    (i_psel),
  .i_penable (i_penable),
  .i_pwrite  (i_pwrite),
  .i_paddr   (i_paddr),
  .i_pwdata  (i_pwdata),
  .o_prdata  (o_prdata),
  .o_pready  (o_pready),
  .o_pslverr (o_pslverr)
);
`default_nettype wire

// ===== sim/bsljx_apb_host.sv
// Bus requester standing in for the decoder side of the unit
`timescale 1ns/1ps
`default_nettype none
module bsljx_apb_host (
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output var  logic        o_psel,
  output var  logic        o_penable,
  output var  logic        o_pwrite,
  output var  logic [7:0]  o_paddr,
  output var  logic [31:0] o_pwdata
);
  // Idle bus at time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // One transfer; request held until ready is sampled high, giving up after 20 cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic t);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (!i_pready && n < 20);
    r = i_prdata;
    e = i_pslverr;
    t = !i_pready;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Stale data would hide a missed capture
    o_pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== sim/bsljx_exec_core_tb_top.sv
// Self-checking bench for the bit search, clamp and long jump unit
`timescale 1ns/1ps
`default_nettype none
`include "bsljx_defines.vh"
module bsljx_exec_core_tb_top;
  logic        i_sys_clk;
  logic        i_rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          failures;
  int          total_checks;

  bsljx_exec_core dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  bsljx_apb_host u_host (.i_sys_clk(i_sys_clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));

  // 20 MHz system clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    total_checks++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, m, s, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    logic t;
    u_host.xfer(w, a, d, r, e, t);
    if (t)
    begin
      failures++;
      $display("[FAIL] %0t no ready", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic        e;
    bus(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
  endtask
  function automatic logic [7:0] wa(input logic [3:0] n);
    return {2'b01, n, 2'b00};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(`BSLJX_ADDR_IR, 32'h0, "ir reset");
    rd(`BSLJX_ADDR_SR, 32'h0, "sr reset");
    rd(`BSLJX_ADDR_PC, 32'h0, "pc reset");
    bus(1'b1, 8'h10, 32'h5, r, e);
    chk({31'h0, e}, 32'h1, "hole write");
    bus(1'b0, 8'h41, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "misaligned read");
    chk(r, 32'h0, "refused data");
  endtask
  // Every bit position edge plus the empty word; other flags preset high
  task automatic t_find_first_set_from_lsb;
    logic [15:0] src [5] = '{16'h000A, 16'h8000, 16'h0001, 16'h0000, 16'hFFFF};
    logic [15:0] res [5] = '{16'h0002, 16'h0010, 16'h0001, 16'h0000, 16'h0001};
    for (int i = 0; i < 5; i++)
    begin
      wr(wa(4'h1), {16'h0, src[i]});
      wr(`BSLJX_ADDR_SR, 32'hE);
      wr(wa(4'h9), 32'hBBBB);
      wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h0, 4'h1});
      rd(wa(4'h9), {16'h0, res[i]}, "search result");
      rd(`BSLJX_ADDR_SR, {28'h7, 3'h7, src[i] == 16'h0} & 32'hF, "search carry");
    end
    wr(wa(4'h1), 32'h4);
    wr(8'h88, 32'h8000);
    wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h2, 4'h1});
    rd(wa(4'h9), 32'h10, "post inc source");
    rd(wa(4'h1), 32'h6, "post inc pointer");
    wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h5, 4'h1});
    rd(wa(4'h1), 32'h4, "pre dec pointer");
    wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h4, 4'h1});
    rd(wa(4'h1), 32'h6, "pre inc pointer");
    rd(wa(4'h9), 32'h0, "pre inc source");
    wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h3, 4'h1});
    rd(wa(4'h1), 32'h4, "post dec pointer");
    wr(`BSLJX_ADDR_IR, {8'h0, 12'hCF0, 1'b0, 4'h9, 3'h1, 4'h1});
    rd(wa(4'h9), 32'h10, "plain indirect source");
    rd(wa(4'h1), 32'h4, "plain indirect pointer");
    // Unrecognised word: flagged, counter still steps one word
    wr(`BSLJX_ADDR_IR, 32'h00123456);
    rd(`BSLJX_ADDR_STAT, 32'h2, "unknown word flagged");
    rd(`BSLJX_ADDR_PC, 32'h16, "one word each");
  endtask
  // Above, below, inside and crossed limits, for all three forms
  task automatic t_clamp;
    logic signed [15:0] sv [4] = '{16'h0064, 16'hFF9C, 16'h0014, 16'h0000};
    logic signed [15:0] up [4] = '{16'h0032, 16'h0032, 16'h0032, 16'hFFF6};
    logic signed [15:0] lo [4] = '{16'hFFCE, 16'hFFCE, 16'hFFCE, 16'h000A};
    logic signed [15:0] q;
    logic signed [15:0] x;
    logic [2:0]         k;
    for (int i = 0; i < 4; i++)
      for (int v = 0; v < 3; v++)
      begin
        wr(wa(4'h2), {16'h0, up[i]});
        wr(wa(4'h3), {16'h0, lo[i]});
        wr(wa(4'h4), {16'h0, sv[i]});
        wr(wa(4'h9), 32'hBBBB);
        wr(`BSLJX_ADDR_SR, 32'h5);
        if (v == 0)
          wr(`BSLJX_ADDR_IR, {8'h0, 8'hE4, 1'b0, 4'h2, 4'h0, 3'h0, 4'h4});
        else
          wr(`BSLJX_ADDR_IR, {8'h0, 8'hE5, v == 2, 4'h2, 4'h9, 3'h0, 4'h4});
        k = (sv[i] > up[i]) ? 3'h4 : (sv[i] < lo[i]) ? 3'h2 : 3'h1;
        q = k[2] ? up[i] : k[1] ? lo[i] : sv[i];
        x = (v == 0) ? 16'hBBBB : k[0] ? 16'h0000 : (v == 1) ? (k[2] ? 16'h0001 : 16'hFFFF)
            : sv[i] - (k[2] ? up[i] : lo[i]);
        rd(wa(4'h4), {16'h0, q}, "clamped source");
        rd(wa(4'h9), {16'h0, x}, "excess result");
        rd(`BSLJX_ADDR_SR, {28'h0, k[1], 1'b0, k[0], 1'b1}, "clamp flags");
      end
  endtask
  // Odd target bit dropped, top of range reached
  task automatic t_jump;
    logic [23:0] w1 [2] = '{24'h04BCD7, 24'h04FFFE};
    logic [23:0] w2 [2] = '{24'h00007A, 24'h00007F};
    for (int i = 0; i < 2; i++)
    begin
      wr(`BSLJX_ADDR_IR, {8'h0, w1[i]});
      rd(`BSLJX_ADDR_STAT, 32'h1, "second word awaited");
      wr(`BSLJX_ADDR_IR, {8'h0, w2[i]});
      rd(`BSLJX_ADDR_PC, {9'h0, w2[i][6:0], w1[i][15:1], 1'b0}, "jump target");
      rd(`BSLJX_ADDR_IR, 32'h0, "fetched word flushed");
    end
  endtask

  // Reset for five cycles, then the scenarios in turn
  initial
  begin
    i_rstn = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_find_first_set_from_lsb();
    t_clamp();
    t_jump();
    end_sim();
  end
endmodule
`default_nettype wire
